// *** rtl/ucp_consts.svh ***
// Purpose: Constants of the ASCII command parser
// Assumes: Included by its bare name
// Notes:   Offsets are APB byte addresses
`ifndef UCP_CONSTS_SVH
`define UCP_CONSTS_SVH
// ==========================================================
// Register map
`define UCP_CTRL_OFS   8'h00
`define UCP_STAT_OFS   8'h04
`define UCP_CTRL_RST   32'h0000_0044
`define UCP_CHK_BIT    0
`define UCP_ERSP_BIT   1
`define UCP_NORM_BIT   2
`define UCP_BAUD_LSB   4
// ==========================================================
// Characters
`define UCP_CH_CR      8'h0d
`define UCP_CH_STD_D   8'h74
`define UCP_CH_STD_R   8'h54
`define UCP_CH_EXT_D   8'h65
`define UCP_CH_EXT_R   8'h45
`define UCP_CH_STAT    8'h53
`define UCP_CH_CLR     8'h43
`define UCP_CH_RST     8'h52
`define UCP_CH_RST2    8'h41
`define UCP_CH_OK      8'h21
`define UCP_CH_ERR     8'h3f
// ==========================================================
// Sizes and error codes
`define UCP_BUF_DEPTH  32
`define UCP_STD_DIG    3
`define UCP_EXT_DIG    8
`define UCP_MAX_DLC    4'h8
`define UCP_ERR_CMD    4'h1
`define UCP_ERR_LEN    4'h2
`define UCP_ERR_HEX    4'h3
`define UCP_ERR_CHK    4'h4
`endif

// *** rtl/ucp_parser.sv ***
// Purpose: ASCII command interpreter between UART and CAN
// Assumes: One clock, bytes arrive already deframed
// Notes:   APB slave holds options and sticky status
`timescale 1ns/1ps
`include "ucp_consts.svh"

module ucp_parser
  import ucp_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             dip_normal,
  input  wire logic             rx_valid,
  input  wire logic [7:0]       rx_data,
  output logic                  rx_ready,
  output logic                  tx_valid,
  output logic      [7:0]       tx_data,
  input  wire logic             tx_ready,
  output logic                  can_tx_valid,
  output ucp_frame_type         can_tx_frame,
  input  wire logic             can_rx_valid,
  input  wire ucp_frame_type    can_rx_frame,
  output logic                  can_rx_ready,
  input  wire ucp_can_stat_type can_stat,
  input  wire logic             can_ovf_evt,
  input  wire logic             uart_ovf_evt,
  output logic                  err_led,
  output logic                  restart
);
  // ========================================================
  // Helpers
  function automatic logic hex_ok(input logic [7:0] c);
    hex_ok = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
          || (c >= 8'h61 && c <= 8'h66);
  endfunction : hex_ok
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    if (c <= 8'h39)
      hex_val = 4'(c - 8'h30);
    else if (c <= 8'h46)
      hex_val = 4'(c - 8'h37);
    else
      hex_val = 4'(c - 8'h57);
  endfunction : hex_val
  function automatic logic [7:0] to_hex(input logic [3:0] n);
    to_hex = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : to_hex

  ucp_state_type state_reg;
  logic [31:0]   ctrl_reg;
  logic [1:0]    ovf_reg;
  logic [3:0]    last_err_reg;
  logic [7:0]    in_buf [`UCP_BUF_DEPTH];
  logic [5:0]    in_cnt_reg;
  logic          in_ovf_reg;
  logic          pend_reg;
  logic [7:0]    out_buf [`UCP_BUF_DEPTH];
  logic [5:0]    out_len_reg;
  logic [4:0]    out_idx_reg;
  logic          chk_en, ersp_en, mode_ok;
  ucp_cmd_type   dec_cmd;
  logic [3:0]    dec_err;
  ucp_frame_type dec_frame;
  logic [7:0]    comp_buf [`UCP_BUF_DEPTH];
  logic [5:0]    comp_len;

  assign chk_en  = ctrl_reg[`UCP_CHK_BIT];
  assign ersp_en = ctrl_reg[`UCP_ERSP_BIT];
  assign mode_ok = dip_normal && ctrl_reg[`UCP_NORM_BIT];

  // ========================================================
  // APB slave
  logic apb_hit;
  assign apb_hit = (paddr == `UCP_CTRL_OFS) || (paddr == `UCP_STAT_OFS);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !apb_hit;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_reg <= `UCP_CTRL_RST;
    else if (psel && penable && pwrite && paddr == `UCP_CTRL_OFS)
      ctrl_reg <= {24'h0, pwdata[7:4], 1'b0, pwdata[2:0]};

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable)
    begin
      if (paddr == `UCP_CTRL_OFS)
        prdata <= ctrl_reg;
      else if (paddr == `UCP_STAT_OFS)
        prdata <= {23'h0, state_reg != UCP_IDLE, last_err_reg,
                   1'b0, err_led, ovf_reg};
      else
        prdata <= 32'h0;
    end

  // ========================================================
  // Input collection
  assign rx_ready = !pend_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      in_cnt_reg <= 6'h0;
      in_ovf_reg <= 1'b0;
      pend_reg   <= 1'b0;
    end
    else if (state_reg == UCP_EXEC)
    begin
      in_cnt_reg <= 6'h0;
      in_ovf_reg <= 1'b0;
      pend_reg   <= 1'b0;
    end
    else if (rx_valid && rx_ready && mode_ok)
    begin
      if (rx_data == `UCP_CH_CR)
        pend_reg <= 1'b1;
      else if (in_cnt_reg == 6'(`UCP_BUF_DEPTH))
        in_ovf_reg <= 1'b1;
      else
        in_cnt_reg <= in_cnt_reg + 6'h1;
    end

  always_ff @(posedge pclk)
    if (rx_valid && rx_ready && mode_ok && rx_data != `UCP_CH_CR
        && in_cnt_reg != 6'(`UCP_BUF_DEPTH))
      in_buf[in_cnt_reg[4:0]] <= rx_data;

  // ========================================================
  // Command decode
  always_comb
  begin
    int idn, blen, expl, nd;
    logic [7:0] c0, sum;
    logic       allhex;
    c0        = in_buf[0];
    idn       = (c0 == `UCP_CH_EXT_D || c0 == `UCP_CH_EXT_R)
              ? `UCP_EXT_DIG : `UCP_STD_DIG;
    blen      = chk_en ? int'(in_cnt_reg) - 2 : int'(in_cnt_reg);
    dec_frame = '0;
    dec_frame.ext = (idn == `UCP_EXT_DIG);
    dec_frame.rtr = (c0 == `UCP_CH_STD_R || c0 == `UCP_CH_EXT_R);
    dec_frame.dlc = hex_val(in_buf[idn + 1]);
    nd     = dec_frame.rtr ? 0 : int'(dec_frame.dlc);
    allhex = 1'b1;
    sum    = 8'h0;
    for (int i = 1; i < `UCP_BUF_DEPTH; i++)
      if (i < int'(in_cnt_reg) && !hex_ok(in_buf[i]))
        allhex = 1'b0;
    for (int i = 0; i < `UCP_BUF_DEPTH; i++)
      if (i < blen)
        sum = sum + in_buf[i];
    for (int i = 1; i <= `UCP_EXT_DIG; i++)
      if (i <= idn)
        dec_frame.id = {dec_frame.id[24:0], hex_val(in_buf[i])};
    for (int k = 0; k < 16; k++)
      if (k < 2 * nd)
        dec_frame.data[63 - 4 * k -: 4] = hex_val(in_buf[idn + 2 + k]);
    dec_cmd = UCP_CMD_NONE;
    expl    = 1;
    case (c0)
      `UCP_CH_STD_D, `UCP_CH_EXT_D:
      begin
        dec_cmd = UCP_CMD_FRAME;
        expl    = idn + 2 + 2 * nd;
      end
      `UCP_CH_STD_R, `UCP_CH_EXT_R:
      begin
        dec_cmd = UCP_CMD_FRAME;
        expl    = idn + 2;
      end
      `UCP_CH_STAT: dec_cmd = UCP_CMD_STAT;
      `UCP_CH_CLR:  dec_cmd = UCP_CMD_CLR;
      `UCP_CH_RST:
      begin
        dec_cmd = (in_buf[1] == `UCP_CH_RST2) ? UCP_CMD_RST : UCP_CMD_NONE;
        expl    = 2;
      end
      default: dec_cmd = UCP_CMD_NONE;
    endcase
    if (in_ovf_reg || blen < 1)
      dec_err = `UCP_ERR_LEN;
    else if (dec_cmd == UCP_CMD_NONE)
      dec_err = `UCP_ERR_CMD;
    else if (blen != expl)
      dec_err = `UCP_ERR_LEN;
    else if (!allhex || (dec_cmd == UCP_CMD_FRAME
             && dec_frame.dlc > `UCP_MAX_DLC))
      dec_err = `UCP_ERR_HEX;
    else if (chk_en && sum != {hex_val(in_buf[blen]),
                               hex_val(in_buf[blen + 1])})
      dec_err = `UCP_ERR_CHK;
    else
      dec_err = 4'h0;
  end

  // ========================================================
  // Reply composer
  always_comb
  begin
    int idn, nd, j;
    logic [31:0] stat;
    logic [7:0]  csum;
    j = 0;
    for (int i = 0; i < `UCP_BUF_DEPTH; i++)
      comp_buf[i] = 8'h0;
    stat = {ctrl_reg[7:4], can_stat.flags, can_stat.tec,
            can_stat.rec, 2'b00, ovf_reg};
    idn  = can_rx_frame.ext ? `UCP_EXT_DIG : `UCP_STD_DIG;
    nd   = (can_rx_frame.rtr || can_rx_frame.dlc > `UCP_MAX_DLC)
         ? 0 : int'(can_rx_frame.dlc);
    csum = 8'h0;
    if (state_reg == UCP_EXEC && dec_err != 4'h0)
    begin
      comp_buf[0] = `UCP_CH_ERR;
      comp_buf[1] = to_hex(dec_err);
      comp_len    = 6'd2;
    end
    else if (state_reg == UCP_EXEC)
    begin
      comp_buf[0] = `UCP_CH_OK;
      for (int i = 1; i <= 8; i++)
        comp_buf[i] = to_hex(4'(stat >> (4 * (8 - i))));
      comp_len = 6'd9;
    end
    else
    begin
      comp_buf[0] = can_rx_frame.ext
        ? (can_rx_frame.rtr ? `UCP_CH_EXT_R : `UCP_CH_EXT_D)
        : (can_rx_frame.rtr ? `UCP_CH_STD_R : `UCP_CH_STD_D);
      for (int i = 1; i < `UCP_BUF_DEPTH; i++)
      begin
        j = i - idn - 2;
        if (i <= idn)
          comp_buf[i] = to_hex(4'(can_rx_frame.id >> (4 * (idn - i))));
        else if (i == idn + 1)
          comp_buf[i] = to_hex(can_rx_frame.dlc);
        else if (j < 2 * nd)
          comp_buf[i] = to_hex(4'(can_rx_frame.data >> (60 - 4 * j)));
      end
      comp_len = 6'(idn + 2 + 2 * nd);
    end
    for (int i = 0; i < `UCP_BUF_DEPTH; i++)
      if (i < int'(comp_len))
        csum = csum + comp_buf[i];
    if (chk_en)
    begin
      comp_buf[comp_len[4:0]]        = to_hex(csum[7:4]);
      comp_buf[5'(comp_len + 6'h1)]  = to_hex(csum[3:0]);
      comp_len = comp_len + 6'd2;
    end
    comp_buf[comp_len[4:0]] = `UCP_CH_CR;
    comp_len = comp_len + 6'd1;
  end

  // ========================================================
  // Sequencer
  logic load_frame, err_reply;
  assign load_frame   = state_reg == UCP_IDLE && !pend_reg && can_rx_valid;
  assign can_rx_ready = load_frame;
  assign err_reply    = dec_err != 4'h0 && ersp_en;
  assign tx_valid     = state_reg == UCP_SEND;
  assign tx_data      = out_buf[out_idx_reg];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      state_reg <= UCP_IDLE;
    else
      case (state_reg)
        UCP_IDLE:
          if (pend_reg)
            state_reg <= UCP_EXEC;
          else if (load_frame)
            state_reg <= UCP_SEND;
        UCP_EXEC:
          if (err_reply || (dec_err == 4'h0 && dec_cmd == UCP_CMD_STAT))
            state_reg <= UCP_SEND;
          else
            state_reg <= UCP_IDLE;
        UCP_SEND:
          if (tx_ready && 6'(out_idx_reg) == out_len_reg - 6'h1)
            state_reg <= UCP_IDLE;
        default: state_reg <= UCP_IDLE;
      endcase

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      out_idx_reg <= 5'h0;
      out_len_reg <= 6'h1;
    end
    else if (load_frame || state_reg == UCP_EXEC)
    begin
      out_idx_reg <= 5'h0;
      out_len_reg <= comp_len;
    end
    else if (tx_valid && tx_ready)
      out_idx_reg <= out_idx_reg + 5'h1;

  always_ff @(posedge pclk)
    if (load_frame || state_reg == UCP_EXEC)
      for (int i = 0; i < `UCP_BUF_DEPTH; i++)
        out_buf[i] <= comp_buf[i];

  // ========================================================
  // Actions and sticky flags
  logic exec_ok;
  assign exec_ok = state_reg == UCP_EXEC && dec_err == 4'h0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      can_tx_valid <= 1'b0;
      can_tx_frame <= '0;
      restart      <= 1'b0;
    end
    else
    begin
      can_tx_valid <= exec_ok && dec_cmd == UCP_CMD_FRAME;
      restart      <= exec_ok && dec_cmd == UCP_CMD_RST;
      if (exec_ok && dec_cmd == UCP_CMD_FRAME)
        can_tx_frame <= dec_frame;
    end

  // New events win over a clear in the same cycle
  logic do_clr;
  assign do_clr = exec_ok && dec_cmd == UCP_CMD_CLR;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ovf_reg      <= 2'b00;
      err_led      <= 1'b0;
      last_err_reg <= 4'h0;
    end
    else
    begin
      ovf_reg <= (do_clr ? 2'b00 : ovf_reg)
               | {uart_ovf_evt, can_ovf_evt};
      err_led <= (err_led && !do_clr) || uart_ovf_evt || can_ovf_evt;
      if (state_reg == UCP_EXEC)
        last_err_reg <= dec_err;
    end

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_exec_frame;
    state_reg == UCP_EXEC && dec_err == 4'h0 && dec_cmd == UCP_CMD_FRAME;
  endsequence
  property p_frame_silent;
    s_exec_frame |=> state_reg == UCP_IDLE && can_tx_valid ##1 !can_tx_valid;
  endproperty
  a_frame_silent: assert property (p_frame_silent)
    else $error("frame command not silent or not sent");
  property p_last_cr;
    tx_valid && tx_ready && 6'(out_idx_reg) == out_len_reg - 6'h1
      |-> tx_data == `UCP_CH_CR;
  endproperty
  a_last_cr: assert property (p_last_cr)
    else $error("reply not ended by carriage return");
  property p_err_silent;
    state_reg == UCP_EXEC && dec_err != 4'h0 && !ersp_en
      |=> state_reg == UCP_IDLE;
  endproperty
  a_err_silent: assert property (p_err_silent)
    else $error("error reply sent while disabled");
  property p_err_reply;
    state_reg == UCP_EXEC && dec_err != 4'h0 && ersp_en
      |=> tx_valid && tx_data == `UCP_CH_ERR;
  endproperty
  a_err_reply: assert property (p_err_reply)
    else $error("missing error reply");
  property p_stat_len;
    exec_ok && dec_cmd == UCP_CMD_STAT |=> tx_data == `UCP_CH_OK
      && out_len_reg == (chk_en ? 6'd12 : 6'd10);
  endproperty
  a_stat_len: assert property (p_stat_len)
    else $error("bad status reply");
  property p_mode_gate;
    rx_valid && !mode_ok && state_reg != UCP_EXEC |=> $stable(in_cnt_reg)
      && !$rose(pend_reg);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("character taken outside normal mode");
  property p_clear;
    do_clr && !uart_ovf_evt && !can_ovf_evt |=> ovf_reg == 2'b00 && !err_led;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not clear flags");
  property p_restart;
    exec_ok && dec_cmd == UCP_CMD_RST |=> restart ##1 !restart;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart pulse wrong");
  property p_ovf_sticky;
    can_ovf_evt ##1 (!do_clr [*2]) |-> ovf_reg[0] ##1 ovf_reg[0];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("CAN overflow flag lost");
endmodule : ucp_parser

// *** rtl/ucp_pkg.sv ***
// Purpose: Types of the ASCII command parser
// Assumes: Nothing
// Notes:   Constants live in ucp_consts.svh
package ucp_pkg;
  typedef enum logic [1:0] {
    UCP_IDLE = 2'b00,
    UCP_EXEC = 2'b01,
    UCP_SEND = 2'b11
  } ucp_state_type;
  typedef enum logic [2:0] {
    UCP_CMD_NONE, UCP_CMD_FRAME, UCP_CMD_STAT, UCP_CMD_CLR, UCP_CMD_RST
  } ucp_cmd_type;
  typedef struct packed {
    logic        ext;
    logic        rtr;
    logic [28:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } ucp_frame_type;
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] tec;
    logic [7:0] rec;
  } ucp_can_stat_type;
endpackage : ucp_pkg

// *** tb/uart_can_ascii_command_parser_test.sv ***
// Purpose: Self-checking bench of the ASCII command parser
// Assumes: Zero-wait APB, host model on the serial side
// Notes:   Replies are compared byte by byte including terminator
`timescale 1ns/1ps
`include "ucp_consts.svh"
module uart_can_ascii_command_parser_test
  import ucp_pkg::*;
;
  typedef struct {
    string       cmd;
    bit          fr;
    logic [34:0] hdr;
    logic [63:0] dat;
    string       rep;
  } ucp_row_type;

  logic             pclk;
  logic             presetn = 1'b0;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  logic             dip_normal = 1'b1;
  logic             rx_valid;
  logic [7:0]       rx_data;
  logic             rx_ready;
  logic             tx_valid;
  logic [7:0]       tx_data;
  logic             tx_ready;
  logic             can_tx_valid;
  ucp_frame_type    can_tx_frame;
  logic             can_rx_valid = 1'b0;
  ucp_frame_type    can_rx_frame = '0;
  logic             can_rx_ready;
  ucp_can_stat_type can_stat = {8'h85, 8'h12, 8'ha0};
  logic             can_ovf_evt = 1'b0;
  logic             uart_ovf_evt = 1'b0;
  logic             err_led;
  logic             restart;
  int               n_mismatch = 0;
  int               tests_run = 0;
  int               n_frm = 0;
  int               n_rst = 0;
  int               f0;
  int               sh;
  ucp_frame_type    last_frm;
  logic [31:0]      rd;
  logic             err;

  // Lower-case hex digits are accepted as well
  ucp_row_type rows [10] = '{
    '{"t03F6112233445566", 1'b1, {2'b00, 29'h03f, 4'h6},
      64'h1122_3344_5566_0000, ""},
    '{"T2E88", 1'b1, {2'b01, 29'h2e8, 4'h8}, 64'h0, ""},
    '{"e1234567851122334455", 1'b1, {2'b10, 29'h12345678, 4'h5},
      64'h1122_3344_5500_0000, ""},
    '{"E010156786", 1'b1, {2'b11, 29'h01015678, 4'h6}, 64'h0, ""},
    '{"t0000", 1'b1, {2'b00, 29'h0, 4'h0}, 64'h0, ""},
    '{"t0aB1cd", 1'b1, {2'b00, 29'h0ab, 4'h1}, 64'hcd00_0000_0000_0000, ""},
    '{"T1239", 1'b0, 35'h0, 64'h0, "?3"},
    '{"X12", 1'b0, 35'h0, 64'h0, "?1"},
    '{"t12G0", 1'b0, 35'h0, 64'h0, "?3"},
    '{"t12310", 1'b0, 35'h0, 64'h0, "?2"}
  };

  ucp_parser ucp_parser_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dip_normal(dip_normal),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .can_tx_valid(can_tx_valid), .can_tx_frame(can_tx_frame),
    .can_rx_valid(can_rx_valid), .can_rx_frame(can_rx_frame),
    .can_rx_ready(can_rx_ready), .can_stat(can_stat),
    .can_ovf_evt(can_ovf_evt), .uart_ovf_evt(uart_ovf_evt),
    .err_led(err_led), .restart(restart)
  );

  ucp_host_model ucp_host_model_inst (
    .pclk(pclk), .presetn(presetn), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_ready(tx_ready)
  );

  // ==========================================================
  // Clock, monitors, watchdog
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (can_tx_valid === 1'b1)
      n_frm++;
    if (can_tx_valid === 1'b1)
      last_frm = can_tx_frame;
    if (restart === 1'b1)
      n_rst++;
  end

  // Whole run is about a thousand cycles
  initial
  begin
    #500000;
    n_mismatch++;
    wrap_up();
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Leading edge wait keeps back-to-back calls from double driving
  task automatic apb(input bit w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic run_cmd(input string c, input bit sc, input bit rc,
                         input string e);
    if (c.len() > 0)
      ucp_host_model_inst.send(c, sc);
    if (e.len() > 0 && rc)
      e = {e, ucp_host_model_inst.hx(
             {24'h0, ucp_host_model_inst.sum(e)}, 2)};
    if (e.len() > 0)
      e = {e, "\015"};
    repeat (20) @(posedge pclk);
    for (int n = 0; n < 400 && ucp_host_model_inst.rxq.size() < e.len();
         n++)
      @(posedge pclk);
    chk(ucp_host_model_inst.rxq.size(), e.len());
    for (int i = 0; i < e.len() && i < ucp_host_model_inst.rxq.size(); i++)
      chk(ucp_host_model_inst.rxq[i], e[i]);
    ucp_host_model_inst.rxq.delete();
  endtask : run_cmd

  task automatic can_in(input ucp_frame_type f);
    @(posedge pclk);
    can_rx_valid <= 1'b1;
    can_rx_frame <= f;
    do
      @(posedge pclk);
    while (can_rx_ready !== 1'b1);
    can_rx_valid <= 1'b0;
    can_rx_frame <= ~f;
  endtask : can_in

  task automatic pulse(input logic [1:0] v);
    @(posedge pclk);
    {uart_ovf_evt, can_ovf_evt} <= v;
    @(posedge pclk);
    {uart_ovf_evt, can_ovf_evt} <= 2'b00;
  endtask : pulse

  function automatic string stat_txt(input logic [3:0] b,
                                     input logic [3:0] o);
    return {"!", ucp_host_model_inst.hx({28'h0, b}, 1), "8512A0",
            ucp_host_model_inst.hx({28'h0, o}, 1)};
  endfunction : stat_txt

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({pready, rx_ready, tx_valid, can_tx_valid, err_led, restart},
        6'b110000);
    apb(1'b0, `UCP_CTRL_OFS, 32'h0);
    chk(rd, `UCP_CTRL_RST);
    run_cmd("X", 1'b0, 1'b0, "");
    apb(1'b1, `UCP_CTRL_OFS, 32'h46);
    foreach (rows[i])
    begin
      f0 = n_frm;
      run_cmd(rows[i].cmd, 1'b0, 1'b0, rows[i].rep);
      chk(n_frm - f0, {63'h0, rows[i].fr});
      if (rows[i].fr)
      begin
        sh = 64 - 8 * int'(rows[i].hdr[3:0]);
        chk({last_frm.ext, last_frm.rtr, last_frm.id, last_frm.dlc},
            rows[i].hdr);
        if (!rows[i].hdr[33])
          chk(last_frm.data >> sh, rows[i].dat >> sh);
      end
    end
    ucp_host_model_inst.slow = 1'b1;
    for (int b = 0; b <= 10; b++)
    begin
      apb(1'b1, `UCP_CTRL_OFS, 32'h6 | (32'(b) << 4));
      run_cmd("S", 1'b0, 1'b0, stat_txt(4'(b), 4'h0));
    end
    ucp_host_model_inst.slow = 1'b0;
    pulse(2'b10);
    run_cmd("S", 1'b0, 1'b0, stat_txt(4'ha, 4'h2));
    pulse(2'b01);
    run_cmd("S", 1'b0, 1'b0, stat_txt(4'ha, 4'h3));
    chk(err_led, 1'b1);
    apb(1'b0, `UCP_STAT_OFS, 32'h0);
    chk(rd[8:0], 9'h007);
    run_cmd("C", 1'b0, 1'b0, "");
    chk(err_led, 1'b0);
    run_cmd("S", 1'b0, 1'b0, stat_txt(4'ha, 4'h0));
    can_in('{1'b0, 1'b0, 29'h03f, 4'h2, 64'haabb_0000_0000_0000});
    run_cmd("", 1'b0, 1'b0, "t03F2AABB");
    can_in('{1'b1, 1'b1, 29'h1abcdef0, 4'h3, 64'h0});
    run_cmd("", 1'b0, 1'b0, "E1ABCDEF03");
    apb(1'b1, `UCP_CTRL_OFS, 32'h47);
    f0 = n_rst;
    run_cmd("RA", 1'b1, 1'b1, "");
    chk(n_rst - f0, 64'h1);
    run_cmd("RA00", 1'b0, 1'b1, "?4");
    apb(1'b0, `UCP_STAT_OFS, 32'h0);
    chk(rd[7:4], 4'h4);
    run_cmd("S", 1'b1, 1'b1, stat_txt(4'h4, 4'h0));
    apb(1'b1, `UCP_CTRL_OFS, 32'h43);
    run_cmd("S", 1'b1, 1'b1, "");
    apb(1'b1, `UCP_CTRL_OFS, 32'h47);
    dip_normal <= 1'b0;
    run_cmd("S", 1'b1, 1'b1, "");
    dip_normal <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    // Mid-run reset must drop sticky flags and options
    pulse(2'b01);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `UCP_STAT_OFS, 32'h0);
    chk(rd[8:0], 9'h000);
    apb(1'b0, `UCP_CTRL_OFS, 32'h0);
    chk(rd, `UCP_CTRL_RST);
    wrap_up();
  end
endmodule : uart_can_ascii_command_parser_test

// *** tb/ucp_host_model.sv ***
// Purpose: Serial host facing the command parser
// Assumes: One byte per rx handshake, replies kept in arrival order
// Notes:   Released rx lines show the inverse of the last byte
`timescale 1ns/1ps
`include "ucp_consts.svh"
module ucp_host_model
  import ucp_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            tx_ready
);
  logic       slow;
  logic [7:0] rxq [$];

  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    slow     = 1'b0;
  end

  // ==========================================================
  // Text helpers
  function automatic logic [7:0] sum(input string s);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < s.len(); i++)
      acc = acc + 8'(s[i]);
    return acc;
  endfunction : sum

  function automatic string hx(input logic [31:0] v, input int n);
    string digits;
    string s;
    digits = "0123456789ABCDEF";
    s = "";
    for (int i = n - 1; i >= 0; i--)
      s = {s, string'(digits[v[i*4 +: 4]])};
    return s;
  endfunction : hx

  // ==========================================================
  // Command sender, back to back bytes
  task automatic send(input string s, input bit ck);
    string f;
    f = ck ? {s, hx({24'h0, sum(s)}, 2)} : s;
    for (int i = 0; i <= f.len(); i++)
    begin
      rx_valid <= 1'b1;
      rx_data  <= (i == f.len()) ? `UCP_CH_CR : f[i];
      do
        @(posedge pclk);
      while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send

  // ==========================================================
  // Reply collector; slow mode stalls every other cycle
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      tx_ready <= 1'b1;
    else
    begin
      if (tx_valid && tx_ready)
        rxq.push_back(tx_data);
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule : ucp_host_model
